// ===== inc/lutp_pkg.sv
/*
 * Shared constants and types for the pixel lookup table processor.
 * Assumes 16-bit internal pixels, three colour components and a
 * single pipeline clock.
 */
package lutp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Table geometry
    localparam int          IDX_W       = 14;
    localparam int          ENT_W       = 16;
    localparam int          ENTRIES     = 16384;
    localparam int          COMPS       = 3;
    localparam int          PIX_W       = 16;
    localparam int          IND_W       = 5;
    localparam logic [4:0]  IDX_W_IND   = 5'h0E;
    localparam logic [4:0]  ENT_W_IND   = 5'h10;
    localparam logic [13:0] IDX_LAST    = 14'h3FFF;
    localparam logic [13:0] IDX_FIRST   = 14'h0000;
    localparam int          IDX_LSB     = 2;

    ////////////////////////////////////////////////////////////////////////
    // Style, mode, component and exponent codes
    localparam logic        STYLE_COMPLETE  = 1'b0;
    localparam logic        STYLE_SEGMENTED = 1'b1;
    localparam logic        MODE_COMPUTED   = 1'b0;
    localparam logic        MODE_CUSTOM     = 1'b1;
    localparam logic [1:0]  COMP_RED        = 2'h0;
    localparam logic [1:0]  COMP_GREEN      = 2'h1;
    localparam logic [1:0]  COMP_BLUE       = 2'h2;
    localparam logic [1:0]  EXP_ONE         = 2'h0;
    localparam logic [1:0]  EXP_TWO         = 2'h1;
    localparam logic [1:0]  EXP_HALF        = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Curve number formats and reset values
    localparam int           SHIFT_W     = 18;
    localparam int           FACTOR_W    = 30;
    localparam int           FRAC_W      = 16;
    localparam logic [17:0]  SHIFT_RST   = 18'h00000;
    localparam logic [29:0]  FACTOR_ONE  = 30'h00010000;
    localparam logic [1:0]   EXP_RST     = 2'h0;
    localparam logic         INV_RST     = 1'b0;
    localparam logic [15:0]  FULL_SCALE  = 16'hFFFF;
    localparam logic [15:0]  ZERO_ENTRY  = 16'h0000;
    localparam logic [3:0]   ROOT_MSB    = 4'hF;
    localparam logic [3:0]   ROOT_LSB    = 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // Buffering
    localparam int           FIFO_DEPTH  = 16;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_INIT  = 3'b001,
        ST_CALC  = 3'b010,
        ST_ROOT  = 3'b011,
        ST_STORE = 3'b100
    } lutp_state_t;

endpackage

// ===== hdl/lutp_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes DEPTH is a power of two; one clock, async active-low reset.
 */
`timescale 1ns/10ps
module lutp_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 16
) (
    // Clock, reset, enable
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;
    logic [AW:0]      count_d;
    logic             room_q;
    logic             empty_q;
    logic             push;
    logic             pop;

    assign push      = in_valid && room_q;
    assign pop       = out_ready && !empty_q;
    assign in_ready  = room_q;
    assign out_valid = !empty_q;
    assign out_data  = mem[rd_ptr_q];

    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop && !push) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    // Flags held in flops so the fill-side ready has no logic path
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
            room_q   <= 1'b1;
            empty_q  <= 1'b1;
        end else if (ce) begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            count_q <= count_d;
            room_q  <= (count_d != (AW+1)'(DEPTH));
            empty_q <= (count_d == '0);
        end
    end

endmodule

// ===== hdl/lutp_top.sv
/*
 * Pixel lookup table processor: three 16384 x 16 tables, a curve
 * generator, a direct entry port and a buffered pixel stream path.
 * Assumes all control inputs come from logic on REF_CLK and stay
 * stable while the generator runs.
 */
// Functional notes
// - Full programmable table, identity after reset
// - Fourteen-bit table index, width reported
// - Sixteen-bit entries, width reported
// - Style indicator reports complete table
// - Curve settings act only in computed mode
// - Shift, then factor, then exponent, then invert
// - Entry equals curve formula scaled to full
// - Inversion subtracts curve from full scale
// - Clamp entries to zero and full scale
// - Separate tables, shared curve settings
// - Identity settings reproduce input values
// - Shift is signed fraction of full scale
// - Index from pixel top bits, before formatting
// - Enable off by default, disables curve
// - Direct writes and regeneration overwrite each other
`timescale 1ns/10ps
module lutp_top #(
    parameter int FIFO_DEPTH = lutp_pkg::FIFO_DEPTH
) (
    // Clock, reset, enable
    input  wire logic        REF_CLK,
    input  wire logic        NRST,
    input  wire logic        CE,
    // Control
    input  wire logic        TABLE_ENABLE_SWITCH,
    input  wire logic        LOOKUP_MODE_SELECT,
    input  wire logic [17:0] BRIGHTNESS_SHIFT,
    input  wire logic [29:0] CONTRAST_FACTOR,
    input  wire logic [1:0]  POWER_LAW_EXPONENT,
    input  wire logic        CURVE_INVERT,
    // Status
    output logic             TABLE_STYLE_INDICATOR,
    output logic [4:0]       TABLE_INDEX_WIDTH,
    output logic [4:0]       TABLE_ENTRY_WIDTH,
    output logic             TABLE_BUSY,
    // Entry write port
    input  wire logic        WR_VALID,
    output logic             WR_READY,
    input  wire logic [1:0]  WR_COMPONENT,
    input  wire logic [13:0] WR_INDEX,
    input  wire logic [15:0] WR_DATA,
    // Entry readback port
    input  wire logic        RD_REQ,
    input  wire logic [1:0]  RD_COMPONENT,
    input  wire logic [13:0] RD_INDEX,
    output logic             RD_VALID,
    output logic [15:0]      RD_DATA,
    // Pixel input
    input  wire logic        PIX_IN_VALID,
    output logic             PIX_IN_READY,
    input  wire logic [15:0] PIX_IN_RED,
    input  wire logic [15:0] PIX_IN_GREEN,
    input  wire logic [15:0] PIX_IN_BLUE,
    // Pixel output
    output logic             PIX_OUT_VALID,
    input  wire logic        PIX_OUT_READY,
    output logic [15:0]      PIX_OUT_RED,
    output logic [15:0]      PIX_OUT_GREEN,
    output logic [15:0]      PIX_OUT_BLUE
);
    localparam int CW = lutp_pkg::COMPS * lutp_pkg::PIX_W;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);

    lutp_pkg::lutp_state_t state_q;
    lutp_pkg::lutp_state_t state_d;

    logic [13:0]        idx_q;
    logic [17:0]        shift_l_q;
    logic [29:0]        factor_l_q;
    logic [1:0]         exp_l_q;
    logic               inv_l_q;
    logic [15:0]        lin_q;
    logic [15:0]        root_q;
    logic [3:0]         bit_q;
    logic               boot_q;
    logic               wr_ready_q;
    logic               busy_q;
    logic [15:0]        xn;
    logic signed [18:0] sum;
    logic [47:0]        prod;
    logic [15:0]        lin_d;
    logic [15:0]        trial;
    logic [31:0]        trial_sq;
    logic [31:0]        sqr;
    logic [15:0]        curve_v;
    logic [15:0]        fill_data;
    logic               fill_we;
    logic               wr_fire;
    logic               params_differ;
    logic               start;

    ////////////////////////////////////////////////////////////////////////
    // Curve generator datapath

    assign xn = {idx_q, idx_q[13:12]};

    // signed shift in full-scale units added first
    assign sum = $signed({3'b000, xn}) + $signed({shift_l_q[17], shift_l_q});

    // factor applied to the shifted value
    assign prod = factor_l_q * sum[17:0];

    // clamp below zero and above full scale
    always_comb begin
        if (sum[18]) begin
            lin_d = lutp_pkg::ZERO_ENTRY;
        end else if (|prod[47:32]) begin
            lin_d = lutp_pkg::FULL_SCALE;
        end else begin
            lin_d = prod[31:16];
        end
    end

    // Root by bit trial, one bit per cycle, saves a divider
    assign trial    = root_q | (16'h0001 << bit_q);
    assign trial_sq = trial * trial;
    assign sqr      = lin_q * lin_q + {16'h0000, lin_q};

    // exponent stage on the clamped linear value
    always_comb begin
        case (exp_l_q)
            lutp_pkg::EXP_TWO:  curve_v = root_q;
            lutp_pkg::EXP_HALF: curve_v = sqr[31:16];
            default:            curve_v = lin_q;
        endcase
    end

    always_comb begin
        if (state_q == lutp_pkg::ST_INIT) begin
            fill_data = xn;
        end else if (inv_l_q) begin
            fill_data = lutp_pkg::FULL_SCALE - curve_v;
        end else begin
            fill_data = curve_v;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Generator control

    assign params_differ = (BRIGHTNESS_SHIFT != shift_l_q) ||
                           (CONTRAST_FACTOR != factor_l_q) ||
                           (POWER_LAW_EXPONENT != exp_l_q) ||
                           (CURVE_INVERT != inv_l_q);

    // settings only act in computed mode
    // and only while the table is enabled
    assign start = TABLE_ENABLE_SWITCH && params_differ &&
                   (LOOKUP_MODE_SELECT == lutp_pkg::MODE_COMPUTED);

    always_comb begin
        state_d = state_q;
        case (state_q)
            lutp_pkg::ST_IDLE: begin
                if (start) begin
                    state_d = lutp_pkg::ST_CALC;
                end
            end
            lutp_pkg::ST_INIT: begin
                if (idx_q == lutp_pkg::IDX_LAST) begin
                    state_d = lutp_pkg::ST_IDLE;
                end
            end
            lutp_pkg::ST_CALC: begin
                if (exp_l_q == lutp_pkg::EXP_TWO) begin
                    state_d = lutp_pkg::ST_ROOT;
                end else begin
                    state_d = lutp_pkg::ST_STORE;
                end
            end
            lutp_pkg::ST_ROOT: begin
                if (bit_q == lutp_pkg::ROOT_LSB) begin
                    state_d = lutp_pkg::ST_STORE;
                end
            end
            lutp_pkg::ST_STORE: begin
                if (idx_q == lutp_pkg::IDX_LAST) begin
                    state_d = lutp_pkg::ST_IDLE;
                end else begin
                    state_d = lutp_pkg::ST_CALC;
                end
            end
            default: state_d = lutp_pkg::ST_IDLE;
        endcase
    end

    // reset starts an identity fill of every entry
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            state_q <= lutp_pkg::ST_INIT;
            idx_q   <= lutp_pkg::IDX_FIRST;
            boot_q  <= 1'b1;
        end else if (CE) begin
            state_q <= state_d;
            boot_q  <= 1'b0;
            if (state_q == lutp_pkg::ST_IDLE) begin
                idx_q <= lutp_pkg::IDX_FIRST;
            end else if (fill_we) begin
                idx_q <= idx_q + 1'b1;
            end
        end
    end

    // one settings copy shared by all three tables
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            shift_l_q  <= lutp_pkg::SHIFT_RST;
            factor_l_q <= lutp_pkg::FACTOR_ONE;
            exp_l_q    <= lutp_pkg::EXP_RST;
            inv_l_q    <= lutp_pkg::INV_RST;
        end else if (CE && state_q == lutp_pkg::ST_IDLE && start) begin
            shift_l_q  <= BRIGHTNESS_SHIFT;
            factor_l_q <= CONTRAST_FACTOR;
            exp_l_q    <= POWER_LAW_EXPONENT;
            inv_l_q    <= CURVE_INVERT;
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            lin_q  <= lutp_pkg::ZERO_ENTRY;
            root_q <= lutp_pkg::ZERO_ENTRY;
            bit_q  <= lutp_pkg::ROOT_MSB;
        end else if (CE) begin
            if (state_q == lutp_pkg::ST_CALC) begin
                lin_q  <= lin_d;
                root_q <= lutp_pkg::ZERO_ENTRY;
                bit_q  <= lutp_pkg::ROOT_MSB;
            end else if (state_q == lutp_pkg::ST_ROOT) begin
                if (trial_sq <= {lin_q, 16'h0000}) begin
                    root_q <= trial;
                end
                bit_q <= bit_q - 1'b1;
            end
        end
    end

    // direct writes taken only while generator idle
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            wr_ready_q <= 1'b0;
            busy_q     <= 1'b1;
        end else if (CE) begin
            wr_ready_q <= (state_d == lutp_pkg::ST_IDLE);
            busy_q     <= (state_d != lutp_pkg::ST_IDLE);
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            TABLE_INDEX_WIDTH     <= lutp_pkg::IDX_W_IND;
            TABLE_ENTRY_WIDTH     <= lutp_pkg::ENT_W_IND;
            TABLE_STYLE_INDICATOR <= lutp_pkg::STYLE_COMPLETE;
        end else begin
            TABLE_INDEX_WIDTH     <= lutp_pkg::IDX_W_IND;
            TABLE_ENTRY_WIDTH     <= lutp_pkg::ENT_W_IND;
            TABLE_STYLE_INDICATOR <= lutp_pkg::STYLE_COMPLETE;
        end
    end

    assign fill_we    = (state_q == lutp_pkg::ST_INIT) || (state_q == lutp_pkg::ST_STORE);
    assign wr_fire    = WR_VALID && wr_ready_q;
    assign WR_READY   = wr_ready_q;
    assign TABLE_BUSY = busy_q;

    ////////////////////////////////////////////////////////////////////////
    // Input buffer and tables

    logic          f_valid;
    logic          adv;
    logic [CW-1:0] f_data;
    logic          s1_v_q;
    logic          s1_en_q;
    logic          out_v_q;
    logic [1:0]    rb_sel_q;
    logic          rb_v_q;
    logic          rd_v_q;
    logic [15:0]   rd_data_q;
    logic [15:0]   pix_rd [0:2];
    logic [15:0]   s1_pix [0:2];
    logic [15:0]   out_q  [0:2];
    logic [15:0]   rb_rd  [0:2];

    assign adv = !out_v_q || PIX_OUT_READY;

    lutp_fifo #(
        .WIDTH (CW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (REF_CLK),
        .rst_n     (NRST),
        .ce        (CE),
        .in_valid  (PIX_IN_VALID),
        .in_ready  (PIX_IN_READY),
        .in_data   ({PIX_IN_BLUE, PIX_IN_GREEN, PIX_IN_RED}),
        .out_valid (f_valid),
        .out_ready (adv),
        .out_data  (f_data)
    );

    // each component has its own table
    for (genvar c = 0; c < lutp_pkg::COMPS; c++) begin : g_comp
        logic [15:0] mem [0:lutp_pkg::ENTRIES-1];
        logic [15:0] pix;
        logic        dwe;

        assign pix = f_data[c*lutp_pkg::PIX_W +: lutp_pkg::PIX_W];
        assign dwe = wr_fire && (WR_COMPONENT == 2'(c));

        // last writer wins, generator or direct port
        always_ff @(posedge REF_CLK) begin
            if (CE) begin
                if (fill_we) begin
                    mem[idx_q] <= fill_data;
                end else if (dwe) begin
                    mem[WR_INDEX] <= WR_DATA;
                end
                if (RD_REQ) begin
                    rb_rd[c] <= mem[RD_INDEX];
                end
                if (adv) begin
                    pix_rd[c] <= mem[pix[15:lutp_pkg::IDX_LSB]];
                    s1_pix[c] <= pix;
                end
            end
        end

        // bypass keeps the full 16-bit value
        always_ff @(posedge REF_CLK or negedge NRST) begin
            if (!NRST) begin
                out_q[c] <= lutp_pkg::ZERO_ENTRY;
            end else if (CE && adv) begin
                out_q[c] <= s1_en_q ? pix_rd[c] : s1_pix[c];
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            s1_v_q  <= 1'b0;
            s1_en_q <= 1'b0;
            out_v_q <= 1'b0;
        end else if (CE && adv) begin
            s1_v_q  <= f_valid;
            s1_en_q <= TABLE_ENABLE_SWITCH;
            out_v_q <= s1_v_q;
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            rb_v_q    <= 1'b0;
            rb_sel_q  <= lutp_pkg::COMP_RED;
            rd_v_q    <= 1'b0;
            rd_data_q <= lutp_pkg::ZERO_ENTRY;
        end else if (CE) begin
            rb_v_q   <= RD_REQ;
            rb_sel_q <= RD_COMPONENT;
            rd_v_q   <= rb_v_q;
            if (rb_v_q) begin
                case (rb_sel_q)
                    lutp_pkg::COMP_GREEN: rd_data_q <= rb_rd[1];
                    lutp_pkg::COMP_BLUE:  rd_data_q <= rb_rd[2];
                    default:              rd_data_q <= rb_rd[0];
                endcase
            end
        end
    end

    assign RD_VALID      = rd_v_q;
    assign RD_DATA       = rd_data_q;
    assign PIX_OUT_VALID = out_v_q;
    assign PIX_OUT_RED   = out_q[0];
    assign PIX_OUT_GREEN = out_q[1];
    assign PIX_OUT_BLUE  = out_q[2];

    ////////////////////////////////////////////////////////////////////////
    // Checks

    boot_init_a: assert property (boot_q |-> state_q == lutp_pkg::ST_INIT)
        else $error("table not initialising after reset");

    idx_width_a: assert property (TABLE_INDEX_WIDTH == 5'h0E)
        else $error("index width indicator wrong");

    entry_width_a: assert property (TABLE_ENTRY_WIDTH == 5'h10)
        else $error("entry width indicator wrong");

    style_ind_a: assert property (TABLE_STYLE_INDICATOR == lutp_pkg::STYLE_COMPLETE)
        else $error("style indicator not complete table");

    fill_gate_a: assert property (
        (state_q == lutp_pkg::ST_CALC && $past(state_q) == lutp_pkg::ST_IDLE)
        |-> $past(TABLE_ENABLE_SWITCH) && $past(LOOKUP_MODE_SELECT) == lutp_pkg::MODE_COMPUTED)
        else $error("curve fill started outside computed mode");

    clamp_low_a: assert property (
        (CE && state_q == lutp_pkg::ST_CALC && sum[18]) |=> lin_q == 16'h0000)
        else $error("negative entry not clamped to zero");

    clamp_high_a: assert property (
        (CE && state_q == lutp_pkg::ST_CALC && !sum[18] && |prod[47:32])
        |=> lin_q == 16'hFFFF)
        else $error("entry not saturated to full scale");

    invert_sum_a: assert property (
        (state_q == lutp_pkg::ST_STORE && inv_l_q && exp_l_q == lutp_pkg::EXP_ONE)
        |-> (fill_data + lin_q) == 16'hFFFF)
        else $error("inverted entry not complement of curve");

    identity_a: assert property (
        (state_q == lutp_pkg::ST_STORE && shift_l_q == 18'h00000 &&
         factor_l_q == 30'h00010000 && exp_l_q == 2'h0 && !inv_l_q)
        |-> fill_data == {idx_q, idx_q[13:12]})
        else $error("identity settings do not give identity entry");

    bypass_a: assert property (
        (CE && adv && s1_v_q && !s1_en_q) |=> PIX_OUT_RED == $past(s1_pix[0]))
        else $error("disabled table altered pixel");

endmodule

// ===== bench/lutp_stream_model.sv
/*
 * Pixel source and sink standing either side of the lookup processor.
 * Assumes the bench fills txq and reads rxq; random sink stalls.
 */
`timescale 1ns/10ps
module lutp_stream_model (
    // Clock
    input  wire logic        clk,
    input  wire logic        ce,
    // Source side
    output logic             in_valid,
    input  wire logic        in_ready,
    output logic [15:0]      in_r,
    output logic [15:0]      in_g,
    output logic [15:0]      in_b,
    // Sink side
    input  wire logic        out_valid,
    output logic             out_ready,
    input  wire logic [15:0] out_r,
    input  wire logic [15:0] out_g,
    input  wire logic [15:0] out_b
);
    logic [47:0] txq[$];
    logic [47:0] rxq[$];
    logic        tk;
    logic        gv;
    initial begin
        in_valid  = 1'b0;
        {in_r, in_g, in_b} = 48'h0;
        out_ready = 1'b0;
    end
    // Flops only move on rising edges, so mid-cycle sampling is safe
    always @(negedge clk) begin
        tk = ce && in_valid && in_ready;
        gv = ce && out_valid && out_ready;
        if (gv)
            rxq.push_back({out_r, out_g, out_b});
    end
    always @(posedge clk) begin
        if (tk)
            void'(txq.pop_front());
        #5;
        in_valid = (txq.size() != 0);
        // Idle data lines toggle so stale values never match
        {in_r, in_g, in_b} = in_valid ? txq[0] : ~{in_r, in_g, in_b};
        out_ready = ($urandom_range(99) > 30);
    end
endmodule

// ===== bench/lutp_top_bench.sv
/*
 * Self-checking bench for the lookup table processor.
 * Assumes identity and inverted shifted curves; exponent 1.0 only.
 */
`timescale 1ns/10ps
module lutp_top_bench;
    logic        clk = 1'b0, nrst = 1'b0, en = 1'b0, inv = 1'b0;
    logic        mode = lutp_pkg::MODE_CUSTOM, wr_valid = 1'b0, rd_req = 1'b0;
    logic [17:0] shift = 18'h00000;
    logic [29:0] fac = lutp_pkg::FACTOR_ONE;
    logic [1:0]  wr_c = 2'h0, rd_c = 2'h0;
    logic [13:0] wr_i = 14'h0000, rd_i = 14'h0000, wi;
    logic [15:0] wr_d = 16'h0000, rd_data, ir, ig, ib, o_r, o_g, o_b;
    logic        style, busy, wr_ready, rd_valid, iv, irdy, ov, ordy, t_inv;
    logic [4:0]  iw, ew;
    logic [15:0] wt[int];
    logic [47:0] exq[$];
    int          checks = 0, n_errors = 0, t_sh = 0, t_fa = 32'h10000, k;
    always #25 clk = ~clk;
    lutp_top u_dut (.REF_CLK(clk), .NRST(nrst), .CE(1'b1), .TABLE_ENABLE_SWITCH(en),
        .LOOKUP_MODE_SELECT(mode), .BRIGHTNESS_SHIFT(shift), .CONTRAST_FACTOR(fac),
        .POWER_LAW_EXPONENT(lutp_pkg::EXP_ONE), .CURVE_INVERT(inv), .TABLE_STYLE_INDICATOR(style),
        .TABLE_INDEX_WIDTH(iw), .TABLE_ENTRY_WIDTH(ew), .TABLE_BUSY(busy), .WR_VALID(wr_valid),
        .WR_READY(wr_ready), .WR_COMPONENT(wr_c), .WR_INDEX(wr_i), .WR_DATA(wr_d),
        .RD_REQ(rd_req), .RD_COMPONENT(rd_c), .RD_INDEX(rd_i), .RD_VALID(rd_valid),
        .RD_DATA(rd_data), .PIX_IN_VALID(iv), .PIX_IN_READY(irdy), .PIX_IN_RED(ir),
        .PIX_IN_GREEN(ig), .PIX_IN_BLUE(ib), .PIX_OUT_VALID(ov), .PIX_OUT_READY(ordy),
        .PIX_OUT_RED(o_r), .PIX_OUT_GREEN(o_g), .PIX_OUT_BLUE(o_b));
    lutp_stream_model u_model (.clk(clk), .ce(1'b1), .in_valid(iv), .in_ready(irdy),
        .in_r(ir), .in_g(ig), .in_b(ib), .out_valid(ov), .out_ready(ordy),
        .out_r(o_r), .out_g(o_g), .out_b(o_b));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] ent(logic [1:0] c, logic [13:0] x);
        longint s;
        if (wt.exists(int'({c, x})))
            return wt[int'({c, x})];
        s = ((longint'({x, x[13:12]}) + t_sh) * t_fa) >>> 16;
        if (s < 0)
            s = 0;
        if (s > 65535)
            s = 65535;
        return t_inv ? 16'hFFFF - 16'(s) : 16'(s);
    endfunction
    task automatic conclude;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(logic [47:0] got, logic [47:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    task automatic idle(int lim);
        int j;
        for (j = 0; j < lim && busy !== 1'b0; j++)
            cyc(1);
        if (busy !== 1'b0) begin
            n_errors++;
            $display("Error %0t: table stays busy", $time);
            conclude();
        end
    endtask
    task automatic wr(logic [1:0] c, logic [13:0] i, logic [15:0] d);
        {wr_c, wr_i, wr_d, wr_valid} = {c, i, d, 1'b1};
        idle(50);
        chk(48'(wr_ready), 48'h1);
        cyc(1);
        wr_valid = 1'b0;
        wt[int'({c, i})] = d;
        cyc(1);
    endtask
    task automatic rd(logic [1:0] c, logic [13:0] i);
        {rd_c, rd_i, rd_req} = {c, i, 1'b1};
        cyc(1);
        rd_req = 1'b0;
        cyc(1);
        chk(48'(rd_valid), 48'h1);
        chk(48'(rd_data), 48'(ent(c, i)));
    endtask
    task automatic rd_set(int n);
        for (k = 0; k < n; k++)
            rd(2'($urandom_range(2)), k < 2 ? {14{k[0]}} : 14'($urandom));
    endtask
    task automatic px(logic [47:0] p);
        u_model.txq.push_back(p);
        exq.push_back(en ? {ent(0, p[47:34]), ent(1, p[31:18]), ent(2, p[15:2])} : p);
    endtask
    task automatic flush(int n);
        int j;
        repeat (n) px(48'({$urandom, $urandom}));
        for (j = 0; j < 900 && u_model.rxq.size() < exq.size(); j++)
            cyc(1);
        chk(48'(u_model.rxq.size()), 48'(exq.size()));
        while (u_model.rxq.size() != 0 && exq.size() != 0)
            chk(u_model.rxq.pop_front(), exq.pop_front());
        exq.delete();
        u_model.rxq.delete();
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h6993));
        t_inv = 1'b0;
        repeat (10) @(posedge clk);
        chk(48'(busy), 48'h1);
        #5 nrst = 1'b1;
        idle(17000);
        chk(48'({style, iw, ew}), 48'({lutp_pkg::STYLE_COMPLETE, 5'h0E, 5'h10}));
        rd_set(12);
        flush(30);
        en = 1'b1;
        wi = 14'($urandom);
        for (k = 0; k < 3; k++)
            wr(2'(k), wi, 16'($urandom));
        for (k = 0; k < 3; k++)
            rd(2'(k), wi);
        for (k = 0; k < 4; k++)
            px({wi, 2'(k), wi, 2'(k), wi, 2'(k)});
        flush(30);
        // Negative shift and 1.5 factor reach both clamps
        {inv, shift, fac} = {1'b1, 18'h3C000, 30'h00018000};
        cyc(4);
        chk(48'(busy), 48'h0);
        mode = lutp_pkg::MODE_COMPUTED;
        cyc(3);
        chk(48'(busy), 48'h1);
        t_inv = 1'b1;
        t_sh = -16384;
        t_fa = 32'h18000;
        wt.delete();
        idle(40000);
        rd(2'h0, wi);
        rd_set(12);
        flush(30);
        wr(2'h1, wi, 16'($urandom));
        rd(2'h1, wi);
        {inv, shift, fac} = {1'b0, 18'h00000, lutp_pkg::FACTOR_ONE};
        cyc(3);
        chk(48'(busy), 48'h1);
        t_inv = 1'b0;
        t_sh = 0;
        t_fa = 32'h10000;
        wt.delete();
        idle(40000);
        rd(2'h1, wi);
        rd_set(12);
        flush(20);
        conclude();
    end
endmodule
